// ===== design/phy_mgmt_pkg.sv
/*
 * phy_mgmt_pkg: constants, states and carriers shared by the management
 * port, its station model and its testbench.
 * Assumes a 200 MHz core clock and a slow management clock from outside.
 */
package phy_mgmt_pkg;

   // -------------------------------------------------------------------
   // clocking and frame constants
   // -------------------------------------------------------------------
   localparam int CLK_PERIOD_PS    = 5000;
   localparam int MDC_MIN_EDGE_NS  = 160;   // least time between edges
   localparam int MDC_MIN_CYCLE_NS = 400;   // least like-edge spacing
   localparam int MDC_EDGE_CYCLES  = (MDC_MIN_EDGE_NS * 1000) / CLK_PERIOD_PS;
   localparam int PREAMBLE_ONES    = 32;
   localparam int HDR_BITS         = 12;    // opcode, phy and reg address
   localparam int DATA_BITS        = 16;
   localparam int TA_BITS          = 2;

   localparam logic [1:0]  OP_READ      = 2'h2;
   localparam logic [1:0]  OP_WRITE     = 2'h1;
   localparam logic [4:0]  STD_LAST_REG = 5'h06;
   localparam logic [4:0]  VND_FIRST    = 5'h10;
   localparam logic [4:0]  ANY_ADDR_REG = 5'h11;
   localparam int          ANY_ADDR_BIT = 3;
   localparam logic [15:0] UNIMPL_DATA  = 16'hFFFF;
   localparam logic [4:0]  ADDR_DEFAULT = 5'h1F;

   // -------------------------------------------------------------------
   // apb register map (byte addresses) and fields
   // -------------------------------------------------------------------
   localparam logic [7:0]  APB_STATUS = 8'h00;  // sticky events, read clears
   localparam logic [7:0]  APB_MASK   = 8'h04;  // event enables
   localparam logic [7:0]  APB_CTRL   = 8'h08;  // bit 0 port enable
   localparam logic [7:0]  APB_STRAP  = 8'h0C;  // latched straps
   localparam logic [7:0]  APB_LAST   = 8'h10;  // last frame reg and data
   localparam int          EV_WIDTH   = 3;
   localparam int          EV_WRITE   = 0;
   localparam int          EV_READ    = 1;
   localparam int          EV_FOREIGN = 2;
   localparam logic [2:0]  MASK_RESET = 3'h0;
   localparam logic        CTRL_RESET = 1'h1;
   localparam int          IRQ_MODE_BIT = 5;
   localparam int          LAST_REG_LSB = 16;

   // -------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_HDR   = 3'b010,
      ST_TA    = 3'b011,
      ST_WDATA = 3'b100,
      ST_RDATA = 3'b101
   } frame_state_t;

   typedef struct packed {
      logic [1:0] op;
      logic [4:0] phy;
      logic [4:0] reg_addr;
   } frame_hdr_t;

   typedef struct packed {
      logic       irq_mode;   // 1: interrupt output, 0: tx extra data bit
      logic [4:0] phy_addr;
   } strap_t;

endpackage : phy_mgmt_pkg

// ===== design/sync2.sv
/*
 * sync2: two flip-flop synchroniser for a bundle of independent levels.
 * Assumes each bit changes slowly compared with the core clock.
 */
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             ce_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule // sync2

// ===== design/mgmt_reg_mem.sv
/*
 * mgmt_reg_mem: storage for the management registers, one write port and
 * a registered read port.
 * Assumes the caller filters out addresses that must not be stored.
 */
`timescale 1ns/1ps
module mgmt_reg_mem #(
   parameter int DEPTH = 32,
   parameter int WIDTH = 16
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     ce_i,
   input  wire logic                     we_i,
   input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
   input  wire logic [WIDTH-1:0]         wdata_i,
   input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
   output logic      [WIDTH-1:0]         rdata_o
);
   logic [WIDTH-1:0] mem_reg [DEPTH];

   // storage clears on reset, read data always registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
         rdata_o <= '0;
      end else if (ce_i) begin
         if (we_i) mem_reg[waddr_i] <= wdata_i;
         rdata_o <= mem_reg[raddr_i];
      end
   end
endmodule // mgmt_reg_mem

// ===== design/phy_mgmt_port.sv
/*
 * phy_mgmt_port: serial management port of a transceiver with its
 * configuration straps, led polarity, shared pin role and an apb window
 * for events and status.
 * Assumes mdc and mdio come from a station outside the core clock domain
 * and that strap pins are stable while reset is held.
 */
`timescale 1ns/1ps
module phy_mgmt_port (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             irq_o,
   // management link
   input  wire logic        mdc_i,
   input  wire logic        mdio_i,
   output logic             mdio_o,
   output logic             mdio_oe_n_o,
   // strap and led pins
   input  wire logic        rx_data_3_i,
   input  wire logic [3:0]  led_pin_i,
   output logic      [3:0]  led_pin_o,
   output logic      [3:0]  led_oe_n_o,
   input  wire logic [3:0]  led_on_i,
   input  wire logic        general_out_1_i,
   output logic             general_out_1_o,
   output logic             general_out_1_oe_n_o,
   input  wire logic        general_out_value_i,
   // shared pin: tx extra data bit or interrupt output
   input  wire logic        shared_pin_i,
   output logic             shared_pin_o,
   output logic             shared_oe_n_o,
   output logic             tx_extra_data_bit_o,
   input  wire logic        phy_event_i
);

   // -------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------
   localparam int NSYNC = 9;
   logic [NSYNC-1:0] pins_s;
   logic             mdc_s;
   logic             mdio_s;
   logic             rxd3_s;
   logic [3:0]       led_s;
   logic             gpo_s;
   logic             shared_s;

   sync2 #(.WIDTH(NSYNC)) u_sync (
      .clk_i (clk_i),
      .ce_i  (ce_i),
      .d_i   ({mdc_i, mdio_i, rx_data_3_i, led_pin_i, general_out_1_i,
               shared_pin_i}),
      .q_o   (pins_s)
   );
   assign {mdc_s, mdio_s, rxd3_s, led_s, gpo_s, shared_s} = pins_s;

   // -------------------------------------------------------------------
   // straps
   // -------------------------------------------------------------------
   phy_mgmt_pkg::strap_t strap_reg;
   logic                 strap_done_reg;

   // first enabled edge after reset release catches the strap levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_reg      <= '{irq_mode: 1'b1,
                             phy_addr: phy_mgmt_pkg::ADDR_DEFAULT};
         strap_done_reg <= 1'b0;
      end else if (ce_i && !strap_done_reg) begin
         strap_reg.irq_mode <= rxd3_s;
         strap_reg.phy_addr <= {gpo_s, led_s};
         strap_done_reg     <= 1'b1;
      end
   end

   // led pins driven only after straps are caught, polarity from strap
   logic [3:0] led_pin_reg;
   logic       gpo_pin_reg;
   logic       txd_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         led_pin_reg <= 4'h0;
         gpo_pin_reg <= 1'b0;
         txd_reg     <= 1'b0;
      end else if (ce_i) begin
         led_pin_reg <= led_on_i ^ strap_reg.phy_addr[3:0];
         gpo_pin_reg <= general_out_value_i;
         txd_reg     <= shared_s & ~strap_reg.irq_mode;
      end
   end
   assign led_pin_o            = led_pin_reg;
   assign led_oe_n_o           = {4{~strap_done_reg}};
   assign general_out_1_o      = gpo_pin_reg;
   assign general_out_1_oe_n_o = ~strap_done_reg;
   assign tx_extra_data_bit_o  = txd_reg;

   // shared pin as open-drain interrupt only in interrupt mode
   logic irq_out_n;
   assign irq_out_n     = ~phy_event_i;
   assign shared_pin_o  = 1'b0;
   assign shared_oe_n_o = ~(strap_done_reg & strap_reg.irq_mode
                            & ~irq_out_n);

   // -------------------------------------------------------------------
   // management clock edges
   // -------------------------------------------------------------------
   logic mdc_d_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) mdc_d_reg <= 1'b0;
      else if (ce_i) mdc_d_reg <= mdc_s;
   end
   wire mdc_rise = ce_i & mdc_s & ~mdc_d_reg;
   wire mdc_fall = ce_i & ~mdc_s & mdc_d_reg;

   // -------------------------------------------------------------------
   // frame decode
   // -------------------------------------------------------------------
   phy_mgmt_pkg::frame_state_t   state_reg, state_next;
   logic [5:0]                   cnt_reg, cnt_next;
   logic [15:0]                  shift_reg, shift_next;
   phy_mgmt_pkg::frame_hdr_t     hdr_reg, hdr_next;
   logic                         drive_reg, drive_next;
   logic                         any_addr_reg;
   logic                         port_en_reg;
   logic [15:0]                  mem_rdata;

   wire phy_match = any_addr_reg
                  | (hdr_reg.phy == strap_reg.phy_addr);
   wire hdr_last  = (cnt_reg == 6'(phy_mgmt_pkg::HDR_BITS - 1));
   wire [4:0] reg_a = hdr_reg.reg_addr;
   wire reg_impl  = (reg_a <= phy_mgmt_pkg::STD_LAST_REG)
                  | (reg_a >= phy_mgmt_pkg::VND_FIRST);
   wire [15:0] rd_word = reg_impl ? mem_rdata
                                  : phy_mgmt_pkg::UNIMPL_DATA;
   wire is_read   = (hdr_reg.op == phy_mgmt_pkg::OP_READ);
   wire acting    = phy_match & port_en_reg;
   wire wr_fire   = (state_reg == phy_mgmt_pkg::ST_WDATA) & mdc_rise
                  & (cnt_reg == 6'(phy_mgmt_pkg::DATA_BITS - 1));
   wire wr_mem    = wr_fire & acting & reg_impl;
   wire [15:0] wr_word = {shift_reg[14:0], mdio_s};
   wire rd_fire   = (state_reg == phy_mgmt_pkg::ST_RDATA) & mdc_fall
                  & (cnt_reg == 6'(phy_mgmt_pkg::DATA_BITS));
   wire hdr_done  = (state_reg == phy_mgmt_pkg::ST_HDR) & mdc_rise
                  & hdr_last;
   wire hdr_op_ok = (hdr_next.op == phy_mgmt_pkg::OP_READ)
                  | (hdr_next.op == phy_mgmt_pkg::OP_WRITE);
   wire foreign   = hdr_done & hdr_op_ok & ~(any_addr_reg
                  | (hdr_next.phy == strap_reg.phy_addr));

   // frame walker; waits on clock edges forever, no timeout
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      shift_next = shift_reg;
      hdr_next   = hdr_reg;
      drive_next = drive_reg;
      unique case (state_reg)
         phy_mgmt_pkg::ST_IDLE: begin
            if (mdc_rise) begin
               if (mdio_s) begin
                  if (cnt_reg != 6'(phy_mgmt_pkg::PREAMBLE_ONES))
                     cnt_next = cnt_reg + 6'h01;
               end else if (cnt_reg == 6'(phy_mgmt_pkg::PREAMBLE_ONES)) begin
                  state_next = phy_mgmt_pkg::ST_START;
               end else begin
                  cnt_next = 6'h00;
               end
            end
         end
         phy_mgmt_pkg::ST_START: begin
            if (mdc_rise) begin
               cnt_next   = 6'h00;
               state_next = mdio_s ? phy_mgmt_pkg::ST_HDR
                                   : phy_mgmt_pkg::ST_IDLE;
            end
         end
         phy_mgmt_pkg::ST_HDR: begin
            if (mdc_rise) begin
               hdr_next = {hdr_reg[10:0], mdio_s};
               cnt_next = cnt_reg + 6'h01;
               if (hdr_last) begin
                  cnt_next   = 6'h00;
                  state_next = hdr_op_ok ? phy_mgmt_pkg::ST_TA
                                         : phy_mgmt_pkg::ST_IDLE;
               end
            end
         end
         phy_mgmt_pkg::ST_TA: begin
            if (mdc_rise) cnt_next = cnt_reg + 6'h01;
            if (is_read && !acting) begin
               cnt_next   = 6'h00;
               state_next = phy_mgmt_pkg::ST_IDLE;
            end else if (is_read && mdc_fall
                         && cnt_reg == 6'(phy_mgmt_pkg::TA_BITS - 1)) begin
               drive_next = 1'b1;
               shift_next = rd_word;
               cnt_next   = 6'h00;
               state_next = phy_mgmt_pkg::ST_RDATA;
            end else if (!is_read && mdc_rise
                         && cnt_reg == 6'(phy_mgmt_pkg::TA_BITS - 1)) begin
               cnt_next   = 6'h00;
               state_next = phy_mgmt_pkg::ST_WDATA;
            end
         end
         phy_mgmt_pkg::ST_WDATA: begin
            if (mdc_rise) begin
               shift_next = wr_word;
               cnt_next   = cnt_reg + 6'h01;
               if (wr_fire) begin
                  cnt_next   = 6'h00;
                  state_next = phy_mgmt_pkg::ST_IDLE;
               end
            end
         end
         phy_mgmt_pkg::ST_RDATA: begin
            // data changes on the fall so it is steady at the rise
            if (mdc_fall) begin
               if (rd_fire) begin
                  drive_next = 1'b0;
                  cnt_next   = 6'h00;
                  state_next = phy_mgmt_pkg::ST_IDLE;
               end else begin
                  drive_next = ~shift_reg[15];
                  shift_next = {shift_reg[14:0], 1'b0};
                  cnt_next   = cnt_reg + 6'h01;
               end
            end
         end
         default: begin
            state_next = phy_mgmt_pkg::ST_IDLE;
            cnt_next   = 6'h00;
            drive_next = 1'b0;
         end
      endcase
   end

   // frame state registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= phy_mgmt_pkg::ST_IDLE;
         cnt_reg   <= 6'h00;
         shift_reg <= 16'h0000;
         hdr_reg   <= '0;
         drive_reg <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         shift_reg <= shift_next;
         hdr_reg   <= hdr_next;
         drive_reg <= drive_next;
      end
   end

   // open drain: pull low only for a zero bit
   assign mdio_o      = 1'b0;
   assign mdio_oe_n_o = ~drive_reg;

   // -------------------------------------------------------------------
   // management register store
   // -------------------------------------------------------------------
   mgmt_reg_mem #(.DEPTH(32), .WIDTH(16)) u_mem (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .we_i    (wr_mem),
      .waddr_i (reg_a),
      .wdata_i (wr_word),
      .raddr_i (reg_a),
      .rdata_o (mem_rdata)
   );

   // copy of the respond-to-any-address bit
   always_ff @(posedge clk_i) begin
      if (rst_i) any_addr_reg <= 1'b0;
      else if (ce_i && wr_mem && reg_a == phy_mgmt_pkg::ANY_ADDR_REG)
         any_addr_reg <= wr_word[phy_mgmt_pkg::ANY_ADDR_BIT];
   end

   // -------------------------------------------------------------------
   // apb slave, events and interrupt
   // -------------------------------------------------------------------
   logic [2:0]  status_reg;
   logic [2:0]  mask_reg;
   logic [20:0] last_reg;
   wire  [2:0]  ev = {foreign, rd_fire & acting, wr_fire & acting};
   wire apb_setup = psel_i & ~penable_i;
   wire apb_acc   = psel_i & penable_i;
   wire hit_stat  = (paddr_i == phy_mgmt_pkg::APB_STATUS);
   wire hit_mask  = (paddr_i == phy_mgmt_pkg::APB_MASK);
   wire hit_ctrl  = (paddr_i == phy_mgmt_pkg::APB_CTRL);
   wire hit_strap = (paddr_i == phy_mgmt_pkg::APB_STRAP);
   wire hit_last  = (paddr_i == phy_mgmt_pkg::APB_LAST);
   wire mapped    = hit_stat | hit_mask | hit_ctrl | hit_strap | hit_last;
   wire wr_ok     = apb_acc & pwrite_i & mapped & ce_i;
   wire rd_clear  = apb_acc & ~pwrite_i & hit_stat & ce_i;
   wire [31:0] rd_mux =
        hit_stat  ? {29'h0000_0000, status_reg}
      : hit_mask  ? {29'h0000_0000, mask_reg}
      : hit_ctrl  ? {31'h0000_0000, port_en_reg}
      : hit_strap ? {26'h000_0000, strap_reg}
      : hit_last  ? {11'h000, last_reg}
      : 32'h0000_0000;

   // read data captured in the setup cycle, answer with no wait state
   always_ff @(posedge clk_i) begin
      if (rst_i) prdata_o <= 32'h0000_0000;
      else if (ce_i && apb_setup) prdata_o <= rd_mux;
   end
   assign pready_o  = 1'b1;
   assign pslverr_o = apb_acc & ~mapped;

   // control, mask, sticky status (set wins over read clear)
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_reg  <= 3'h0;
         mask_reg    <= phy_mgmt_pkg::MASK_RESET;
         port_en_reg <= phy_mgmt_pkg::CTRL_RESET;
         last_reg    <= 21'h00_0000;
      end else if (ce_i) begin
         // a read clears only the bits it returned; a later set stays
         status_reg <= (status_reg & ~({3{rd_clear}} & prdata_o[2:0]))
                     | ev;
         if (wr_ok && hit_mask) mask_reg <= pwdata_i[2:0];
         if (wr_ok && hit_ctrl) port_en_reg <= pwdata_i[0];
         if (wr_fire || (rd_fire && acting))
            last_reg <= {reg_a, wr_fire ? wr_word : rd_word};
      end
   end
   assign irq_o = |(status_reg & mask_reg);

endmodule // phy_mgmt_port

// ===== tb/mgmt_port_props.sv
/* mgmt_port_props: pin checks for the management port.
   Assumes ce_i stays high and straps hold still around reset release. */
`timescale 1ns/1ps
module mgmt_port_props (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       mdc_i,
   input wire logic       mdio_o,
   input wire logic       mdio_oe_n_o,
   input wire logic       rx_data_3_i,
   input wire logic [3:0] led_pin_i,
   input wire logic [3:0] led_pin_o,
   input wire logic [3:0] led_oe_n_o,
   input wire logic [3:0] led_on_i,
   input wire logic       general_out_1_i,
   input wire logic       general_out_1_oe_n_o,
   input wire logic       shared_pin_i,
   input wire logic       shared_oe_n_o,
   input wire logic       tx_extra_data_bit_o,
   input wire logic       phy_event_i
);
   logic       rst_q, ok_q, irq_q;
   logic [4:0] adr_q;
   // copy of the straps, caught at the first edge after release
   always_ff @(posedge clk_i) begin
      rst_q <= rst_i;
      if (rst_i)
         ok_q <= 1'h0;
      else if (rst_q) begin
         ok_q  <= 1'h1;
         irq_q <= rx_data_3_i;
         adr_q <= {general_out_1_i, led_pin_i};
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   property p_od;
      mdio_o == 1'h0;
   endproperty
   a_od: assert property (p_od)
      else $error("data line driven high");
   property p_rel;
      $fell(rst_i) |-> mdio_oe_n_o && led_oe_n_o == 4'hF
         ##[1:2] led_oe_n_o == 4'h0 && !general_out_1_oe_n_o;
   endproperty
   a_rel: assert property (p_rel)
      else $error("pin drive wrong around strap latch");
   property p_pol;
      ok_q && $past(ok_q) |-> led_pin_o == ($past(led_on_i) ^ adr_q[3:0]);
   endproperty
   a_pol: assert property (p_pol)
      else $error("led polarity wrong");
   property p_drv;
      $changed(mdio_oe_n_o) |-> !mdc_i;
   endproperty
   a_drv: assert property (p_drv)
      else $error("data changed while clock high");
   property p_evt;
      !shared_oe_n_o |-> phy_event_i && irq_q && ok_q;
   endproperty
   a_evt: assert property (p_evt)
      else $error("shared pin pulled without cause");
   property p_pull;
      ok_q && irq_q && phy_event_i |-> !shared_oe_n_o;
   endproperty
   a_pull: assert property (p_pull)
      else $error("interrupt not shown on shared pin");
   property p_txb;
      ok_q && !irq_q && $rose(shared_pin_i) |-> ##[1:4] tx_extra_data_bit_o;
   endproperty
   a_txb: assert property (p_txb)
      else $error("extra data bit does not follow pin");
   property p_tx0;
      ok_q && $past(ok_q) && irq_q |-> !tx_extra_data_bit_o;
   endproperty
   a_tx0: assert property (p_tx0)
      else $error("extra data bit active in interrupt mode");
endmodule // mgmt_port_props
bind phy_mgmt_port mgmt_port_props props_u (.clk_i, .rst_i, .mdc_i,
   .mdio_o, .mdio_oe_n_o, .rx_data_3_i, .led_pin_i, .led_pin_o,
   .led_oe_n_o, .led_on_i, .general_out_1_i, .general_out_1_oe_n_o,
   .shared_pin_i, .shared_oe_n_o, .tx_extra_data_bit_o, .phy_event_i);

// ===== tb/mgmt_station.sv
/* mgmt_station: behavioural management station, clock and open-drain data.
   Assumes a pull-up on the data line outside this model. */
`timescale 1ns/1ps
module mgmt_station (
   output logic     mdc_o,
   output logic     low_o,
   input wire logic mdio_i
);
   // clock rests low and the line is released outside frames
   initial begin
      mdc_o = 1'h0;
      low_o = 1'h0;
   end
   // one bit: set while the clock is low, taken on the rise
   task automatic slot(input logic b, input int h, output logic s);
      mdc_o = 1'h0;
      low_o = ~b; // only ever pulls low
      #(h); // h of 200 or more keeps edge and cycle spacing
      mdc_o = 1'h1;
      s = mdio_i;
      #(h);
   endtask
   // whole frame; a read releases the line from turnaround on
   task automatic frame(input logic [1:0] op, input logic [4:0] ph, ra,
                        input logic [15:0] wd, input int h,
                        output logic [15:0] rd);
      logic [63:0] f;
      logic        s;
      f = {32'hFFFF_FFFF, 2'h1, op, ph, ra, 2'h2, wd};
      if (op == phy_mgmt_pkg::OP_READ)
         f[17:0] = 18'h3_FFFF;
      for (int i = 63; i >= 0; i--) begin
         slot(f[i], h, s);
         rd = {rd[14:0], s};
      end
      mdc_o = 1'h0;
      low_o = 1'h0;
   endtask
endmodule // mgmt_station

// ===== tb/tb.sv
/* tb: self-checking bench for the management port and its straps.
   Assumes the design package and the station model are compiled first. */
`timescale 1ns/1ps
module tb;
   logic        clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1;
   logic        psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
   logic [7:0]  paddr_i = 8'h0;
   logic [31:0] pwdata_i = 32'h0, prdata_o;
   logic        pready_o, pslverr_o, irq_o, mdc_i, stn_low, mdio_oe_n_o;
   logic        rx_data_3_i = 1'h0, general_out_1_i = 1'h0;
   logic        shared_pin_i = 1'h0, phy_event_i = 1'h0;
   logic [3:0]  led_pin_i = 4'h0, led_on_i = 4'h0, led_pin_o;
   logic        general_out_value_i = 1'h0, shared_oe_n_o, txb, gpo;
   logic [15:0] mrd;
   integer      seed = 32'hA788_E8BB;
   int          n_fail = 0, num_checks = 0;
   string       nm_q[$];
   logic [31:0] ex_q[$], sn_q[$];
   event        got;
   wire         mdio_i = ~(stn_low | ~mdio_oe_n_o); // pull-up wins idle
   phy_mgmt_port dut_u (.clk_i, .rst_i, .ce_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .irq_o, .mdc_i, .mdio_i, .mdio_o(), .mdio_oe_n_o, .rx_data_3_i,
      .led_pin_i, .led_pin_o, .led_oe_n_o(), .led_on_i, .general_out_1_i,
      .general_out_1_o(gpo), .general_out_1_oe_n_o(), .general_out_value_i,
      .shared_pin_i, .shared_pin_o(), .shared_oe_n_o,
      .tx_extra_data_bit_o(txb), .phy_event_i);
   mgmt_station stn_u (.mdc_o(mdc_i), .low_o(stn_low), .mdio_i);
   // 200 MHz core clock
   always #2.5 clk_i = ~clk_i;
   // queue an expected value beside the value seen
   task automatic note(input string nm, input logic [31:0] ex, sn);
      nm_q.push_back(nm);
      ex_q.push_back(ex);
      sn_q.push_back(sn);
      ->got;
   endtask
   task automatic check(input string nm, input logic [31:0] sn, ex);
      num_checks++;
      if (sn !== ex) begin
         n_fail++;
         $display("unexpected %s exp %h seen %h", nm, ex, sn);
      end
   endtask
   // watcher takes every queued note, oldest first, whenever a result arrives
   always @(got) begin
      while (ex_q.size() > 0)
         check(nm_q.pop_front(), sn_q.pop_front(), ex_q.pop_front());
   end
   // apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      psel_i   <= 1'h1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'h1;
      do @(posedge clk_i); while (pready_o !== 1'h1);
      r = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'h0;
      penable_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] ex,
                        input string nm);
      logic [31:0] r;
      logic        e;
      apb(1'h0, a, 32'h0, r, e);
      note(nm, ex, r);
   endtask
   // management frame, w high for a write, h the clock half period
   task automatic mf(input logic w, input logic [4:0] ph, ra,
                     input logic [15:0] wd, input int h);
      stn_u.frame(w ? phy_mgmt_pkg::OP_WRITE : phy_mgmt_pkg::OP_READ,
                  ph, ra, wd, h, mrd);
      repeat (4) @(posedge clk_i);
   endtask
   // reset with the given strap levels on the pins
   task automatic boot(input logic [4:0] a, input logic m);
      rst_i           <= 1'h1;
      led_pin_i       <= a[3:0];
      general_out_1_i <= a[4];
      rx_data_3_i     <= m;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'h0;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic ledchk(input logic [4:0] a);
      led_on_i <= 4'($random(seed));
      repeat (3) @(posedge clk_i);
      note("led", 32'(led_on_i ^ a[3:0]), 32'(led_pin_o));
   endtask
   task automatic test_done;
      #1;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // watchdog well beyond the expected run
   initial begin
      #500000;
      n_fail++;
      test_done;
   end
   // main sequence
   initial begin
      logic [4:0]  adr;
      logic [15:0] d;
      logic [31:0] r;
      logic        e;
      adr = 5'($random(seed));
      d   = 16'($random(seed));
      @(posedge clk_i);
      boot(adr, 1'h0);
      rdchk(phy_mgmt_pkg::APB_STRAP, 32'(adr), "strap");
      rdchk(phy_mgmt_pkg::APB_MASK, 32'h0, "mask");
      rdchk(phy_mgmt_pkg::APB_CTRL, 32'h1, "ctrl");
      apb(1'h0, 8'h20, 32'h0, r, e);
      note("slverr", 32'h1, 32'(e));
      ledchk(adr);
      // clock enable low holds the general output register still
      ce_i                <= 1'h0;
      general_out_value_i <= 1'h1;
      repeat (4) @(posedge clk_i);
      note("frozen", 32'h0, 32'(gpo));
      ce_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      note("gpo", 32'h1, 32'(gpo));
      shared_pin_i <= 1'h1;
      repeat (6) @(posedge clk_i);
      note("tx bit", 32'h1, 32'(txb));
      mf(1'h1, adr, 5'h10, d, 600);
      note("irq masked", 32'h0, 32'(irq_o));
      apb(1'h1, phy_mgmt_pkg::APB_MASK, 32'h1, r, e);
      note("irq", 32'h1, 32'(irq_o));
      rdchk(phy_mgmt_pkg::APB_STATUS, 32'h1, "status");
      note("irq clear", 32'h0, 32'(irq_o));
      mf(1'h0, adr, 5'h10, 16'h0, 200);
      note("read own", 32'(d), 32'(mrd));
      mf(1'h0, adr, 5'h08, 16'h0, 200);
      note("unimpl", 32'hFFFF, 32'(mrd));
      mf(1'h1, adr ^ 5'h01, 5'h10, ~d, 200);
      mf(1'h0, adr ^ 5'h01, 5'h10, 16'h0, 200);
      note("foreign", 32'hFFFF, 32'(mrd));
      mf(1'h0, adr, 5'h10, 16'h0, 200);
      note("kept", 32'(d), 32'(mrd));
      rdchk(phy_mgmt_pkg::APB_STATUS, 32'h6, "status");
      mf(1'h1, adr, phy_mgmt_pkg::ANY_ADDR_REG, 16'h0008, 200);
      mf(1'h0, adr ^ 5'h01, 5'h10, 16'h0, 200);
      note("any addr", 32'(d), 32'(mrd));
      rdchk(phy_mgmt_pkg::APB_LAST, 32'({5'h10, d}), "last");
      // port disabled: no drive, the line stays pulled up
      apb(1'h1, phy_mgmt_pkg::APB_CTRL, 32'h0, r, e);
      mf(1'h0, adr, 5'h10, 16'h0, 200);
      note("port off", 32'hFFFF, 32'(mrd));
      shared_pin_i <= 1'h0;
      boot(5'h1F, 1'h1);
      rdchk(phy_mgmt_pkg::APB_STRAP, 32'h3F, "default strap");
      ledchk(5'h1F);
      phy_event_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      note("irq pin", 32'h0, 32'(shared_oe_n_o));
      mf(1'h0, 5'h1F, 5'h10, 16'h0, 200);
      note("default addr", 32'h0, 32'(mrd));
      test_done;
   end
endmodule // tb
